/* File: sim/cdx_host_model.sv */
/*
 * Host processor model for the extension register bank: index and data
 * port strobes, the 16-bit index write and port reads.
 * Assumes the bank samples strobes on the rising clock edge.
 */
`timescale 1ns/1ns
module cdx_host_model (
  // Clock
  input  wire logic          clock,
  // Strobes toward the bank
  output cdx_pkg::cdx_host_s host,
  output logic               host_idx16,
  output logic [15:0]        host_word,
  // Read data from the bank
  input  wire logic [7:0]    host_rdata
);
  // Idle bus at time zero
  initial begin
    host = '0;
    host_idx16 = 1'b0;
    host_word = 16'h0000;
  end
  // One strobe for one cycle; the byte lane then flips so stale data never looks live
  task automatic strobe(input logic [3:0] kind, input logic [7:0] value);
    @(posedge clock);
    host <= {kind, value};
    @(posedge clock);
    host <= {4'h0, ~value};
  endtask : strobe
  // Whole vertical position in one word, low five bits fixed
  task automatic put_word(input logic [10:0] pos);
    @(posedge clock);
    host_idx16 <= 1'b1;
    host_word <= {pos, 5'h11};
    @(posedge clock);
    host_idx16 <= 1'b0;
    host_word <= ~{pos, 5'h11};
  endtask : put_word
  // Port read; data taken once the registered answer has landed
  task automatic get(input logic data_port, output logic [7:0] value);
    strobe(data_port ? 4'h1 : 4'h4, ~host.wdata);
    @(posedge clock);
    #1;
    value = host_rdata;
  endtask : get
endmodule : cdx_host_model

/* File: sim/test_cdx_regs.sv */
/*
 * Self-checking bench for the extension register bank.
 * Assumes the host model drives the host port strobes; cycle start and display inputs come from here.
 */
`timescale 1ns/1ns
module test_cdx_regs;
  logic              clock = 1'b0;       // Bank clock
  logic              reset_n = 1'b0;     // Sync reset
  cdx_pkg::cdx_host_s host;              // Host strobes
  logic              host_idx16;         // Word write strobe
  logic [15:0]       host_word;          // Word write data
  logic [7:0]        host_rdata;         // Read data
  cdx_pkg::cdx_cyc_e cyc_start = cdx_pkg::CDX_NONE; // Cycle start
  logic              host_ready;         // Ready pulse
  logic [5:0]        attribute_overscan_field = 6'h2d; // Overscan field
  logic [3:0]        fifo_level = 4'h0;  // FIFO occupancy
  logic              osc_tick = 1'b0;    // Oscillator tick
  cdx_pkg::cdx_pos_s cursor_pos;         // Cursor position
  cdx_pkg::cdx_pos_s icon_pos;           // Icon position
  logic border_from_hidden, mem_pins_oe_n, pixel_div4, mem_div2;
  logic cursor_large, palette_ext, cursor_shown, fifo_refill, mem_clk_en, pixel_clk_en;
  logic [5:0]        border_color_sel;   // Border source
  logic [4:0]        pattern_index;      // Pattern number
  logic [12:0]       pattern_base;       // Pattern offset
  int                miscompares = 0;    // Mismatch count
  int                checked = 0;        // Compare count
  logic [7:0]        d;                  // Last read byte
  int                n;                  // Loop index
  int                m;                  // Memory clock pulses
  int                p;                  // Pixel clock pulses
  // 125 MHz clock
  always #4 clock = ~clock;
  cdx_regs u_cdx_regs (.clock, .reset_n, .host, .host_idx16, .host_word, .host_rdata, .cyc_start,
    .host_ready, .attribute_overscan_field, .fifo_level, .osc_tick, .cursor_pos, .icon_pos,
    .border_from_hidden, .border_color_sel, .mem_pins_oe_n, .pixel_div4, .mem_div2, .cursor_large,
    .palette_ext, .cursor_shown, .pattern_index, .pattern_base, .fifo_refill, .mem_clk_en, .pixel_clk_en);
  cdx_host_model u_cdx_host_model (.clock, .host, .host_idx16, .host_word, .host_rdata);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic settle();
    @(posedge clock);
    #1;
  endtask : settle
  task automatic wr(input logic [7:0] index, input logic [7:0] value);
    u_cdx_host_model.strobe(4'h8, index);
    u_cdx_host_model.strobe(4'h2, value);
    settle();
  endtask : wr
  task automatic rd(input logic [7:0] index);
    u_cdx_host_model.strobe(4'h8, index);
    u_cdx_host_model.get(1'b1, d);
  endtask : rd
  // Cycle start, then cycles counted until ready; bounded
  task automatic wait_ready(input cdx_pkg::cdx_cyc_e kind, input int exp);
    int k;
    @(posedge clock);
    cyc_start <= kind;
    @(posedge clock);
    cyc_start <= cdx_pkg::CDX_NONE;
    #1;
    k = 0;
    while (host_ready !== 1'b1 && k < 20) begin
      settle();
      k++;
    end
    if (k == 20) begin
      miscompares++;
      conclude();
    end else begin
      check("ready delay", 16'(k), 16'(exp));
    end
  endtask : wait_ready
  // Eight oscillator ticks over sixteen cycles, clock enables counted
  task automatic count_ticks();
    m = 0;
    p = 0;
    for (int k = 0; k < 16; k++) begin
      @(posedge clock);
      osc_tick <= (k % 2 == 0);
      #1;
      m += int'(mem_clk_en === 1'b1);
      p += int'(pixel_clk_en === 1'b1);
    end
    @(posedge clock);
    osc_tick <= 1'b0;
  endtask : count_ticks
  // Hang guard
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    // Reset values
    for (n = 8'h11; n <= 8'h16; n++) begin
      rd(8'(n));
      check("reset value", 16'(d), (n == 8'h16) ? 16'h00f0 : 16'h0000);
    end
    // Each path control bit alone, with readback
    for (n = 0; n < 8; n++) begin
      wr(8'h12, 8'(1 << n));
      check("path outputs", 16'({border_from_hidden, mem_pins_oe_n, pixel_div4, mem_div2, 1'b0,
        cursor_large, palette_ext, cursor_shown}), 16'((1 << n) & 8'hf7));
      check("border select", 16'(border_color_sel), (n == 7) ? 16'h0002 : 16'h002d);
      rd(8'h12);
      check("path readback", 16'(d), 16'(1 << n));
    end
    // Word writes steered to cursor, then icon
    wr(8'h12, 8'h00);
    u_cdx_host_model.put_word(11'h5a3);
    wr(8'h12, 8'h08);
    u_cdx_host_model.put_word(11'h2c6);
    settle();
    check("cursor vpos", 16'(cursor_pos.vpos), 16'h05a3);
    check("icon vpos", 16'(icon_pos.vpos), 16'h02c6);
    // Horizontal held until the coarse vertical byte write
    wr(8'h12, 8'h00);
    wr(8'h70, 8'h34);
    check("hpos held", 16'(cursor_pos.hpos), 16'h0000);
    wr(8'hb1, 8'h12);
    check("cursor vpos", 16'(cursor_pos.vpos), 16'h0095);
    check("hpos applied", 16'(cursor_pos.hpos), 16'h01a3);
    check("icon hpos", 16'(icon_pos.hpos), 16'h0000);
    // Index-only write, then index port read
    u_cdx_host_model.strobe(4'h8, 8'hd1);
    u_cdx_host_model.get(1'b0, d);
    check("index low bits", 16'(d[7:5]), 16'h0006);
    // Pattern select, small then large cursor
    wr(8'h13, 8'hff);
    check("pattern index", 16'(pattern_index), 16'h001f);
    check("small base", 16'(pattern_base), 16'h1f00);
    rd(8'h13);
    check("pattern readback", 16'(d), 16'h001f);
    wr(8'h12, 8'h0c);
    check("large base", 16'(pattern_base), 16'h1c00);
    // Scratch bytes written as firmware would, and an unmapped index
    wr(8'h14, 8'ha5);
    wr(8'h15, 8'h5a);
    wr(8'h1f, 8'hff);
    rd(8'h14);
    check("scratch a", 16'(d), 16'h00a5);
    rd(8'h15);
    check("scratch b", 16'(d), 16'h005a);
    rd(8'h1f);
    check("unmapped", 16'(d), 16'h0000);
    // Every wait-state setting, both cycle kinds
    for (n = 0; n < 16; n++) begin
      wr(8'h16, {n[3:0], 4'h0});
      wait_ready(cdx_pkg::CDX_IO, 1 + n[3] + n[2]);
      wait_ready(cdx_pkg::CDX_MEMWR, 2 + n[1:0] + n[3]);
    end
    // Refill threshold edge and the zero setting
    wr(8'h16, 8'h08);
    @(posedge clock);
    fifo_level <= 4'h8;
    settle();
    check("refill at level", 16'(fifo_refill), 16'h0001);
    fifo_level <= 4'h9;
    settle();
    check("refill above", 16'(fifo_refill), 16'h0000);
    wr(8'h16, 8'h00);
    check("refill zero", 16'(fifo_refill), 16'h0001);
    // Clock dividers on, then memory divider off
    wr(8'h12, 8'h30);
    count_ticks();
    check("memory half", 16'(m), 16'h0004);
    check("pixel quarter", 16'(p), 16'h0002);
    wr(8'h12, 8'h00);
    count_ticks();
    check("memory full", 16'(m), 16'h0008);
    conclude();
  end
endmodule : test_cdx_regs

/* File: verilog/cdx_cfg.svh */
/*
 * Offsets, field positions, reset values and extended palette addresses for the
 * cursor and data path extension register bank.
 * Assumes inclusion by bare name from the bank module.
 */
`ifndef CDX_CFG_SVH
`define CDX_CFG_SVH
// ****************************************
// Register indices (low five index bits)
// ****************************************
`define CDX_IDX_VCOARSE   5'h11
`define CDX_IDX_HCOARSE   5'h10
`define CDX_IDX_PATH      5'h12
`define CDX_IDX_PATTERN   5'h13
`define CDX_IDX_SCRATCH_A 5'h14
`define CDX_IDX_SCRATCH_B 5'h15
`define CDX_IDX_TUNING    5'h16
// ****************************************
// Path control field positions
// ****************************************
`define CDX_PC_BORDER     7
`define CDX_PC_MEM_TRI    6
`define CDX_PC_VDIV4      5
`define CDX_PC_MDIV2      4
`define CDX_PC_TARGET     3
`define CDX_PC_CSIZE      2
`define CDX_PC_PAL_EXT    1
`define CDX_PC_CUR_EN     0
// ****************************************
// Reset values
// ****************************************
`define CDX_RST_ZERO      8'h00
`define CDX_RST_TUNING    8'hf0
`define CDX_PAT_MASK      8'h1f
// ****************************************
// Extended palette addresses
// ****************************************
`define CDX_PAL_CUR_BG    4'h0
`define CDX_PAL_BORDER    4'h2
`define CDX_PAL_ICON0     4'h3
`define CDX_PAL_CUR_FG    4'hf
`define CDX_PAT_BASE      3'h0
`endif

/* File: verilog/cdx_pkg.sv */
/*
 * Types shared by the extension register bank.
 * Assumes the constants header is available by bare name.
 */
package cdx_pkg;
  // Host port access, one cycle strobe
  typedef struct packed {
    logic       idx_wr;  // Index port write
    logic       idx_rd;  // Index port read
    logic       dat_wr;  // Data port write
    logic       dat_rd;  // Data port read
    logic [7:0] wdata;   // Write byte
  } cdx_host_s;
  // Wait state request class
  typedef enum logic [1:0] {CDX_NONE, CDX_IO, CDX_MEMWR} cdx_cyc_e;
  // Position target
  typedef struct packed {
    logic [10:0] vpos;   // Vertical position in scanlines
    logic [10:0] hpos;   // Horizontal position
  } cdx_pos_s;
endpackage : cdx_pkg

/* File: verilog/cdx_regs.sv */
/*
 * Cursor, icon and video data path extension register bank.
 * Assumes host index/data strobes synchronous to clock, one strobe per cycle.
 */
// Operation
// - Coarse register holds vertical bits ten..three
// - Index bits seven..five give vertical low bits
// - Sixteen bit index write loads whole position
// - Index-only write readback returns stored low bits
// - Target bit steers positions: cursor or icon
// - Target bit never gates extension bits
// - Border protect picks hidden palette overscan
// - Memory tristate bit floats display memory
// - Divide-by-four bit divides video oscillator
// - Memory divide bit halves memory clock
// - Size bit chooses 32 or 64 cursor
// - Palette bit selects extended sixteen entries
// - Fixed extended palette slot assignments
// - Cursor shown only while enable set
// - Small cursor uses five pattern bits
// - Large cursor uses pattern bits four..two
// - Patterns in 8K of top 32K
// - Two scratch bytes reset to zero
// - Tuning resets upper ones, lower zeros
// - Horizontal value pending until vertical write
// - I/O wait states from bits seven..six
// - Memory write waits two..five plus one
// - FIFO refill request at threshold level
`timescale 1ns/1ns
`include "cdx_cfg.svh"
module cdx_regs (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Host index/data ports
  input  wire cdx_pkg::cdx_host_s host,
  input  wire logic              host_idx16,
  input  wire logic [15:0]       host_word,
  output logic [7:0]             host_rdata,
  // Wait state generation
  input  wire cdx_pkg::cdx_cyc_e cyc_start,
  output logic                   host_ready,
  // Display side inputs
  input  wire logic [5:0]        attribute_overscan_field,
  input  wire logic [3:0]        fifo_level,
  input  wire logic              osc_tick,
  // Display side outputs
  output cdx_pkg::cdx_pos_s      cursor_pos,
  output cdx_pkg::cdx_pos_s      icon_pos,
  output logic                   border_from_hidden,
  output logic [5:0]             border_color_sel,
  output logic                   mem_pins_oe_n,
  output logic                   pixel_div4,
  output logic                   mem_div2,
  output logic                   cursor_large,
  output logic                   palette_ext,
  output logic                   cursor_shown,
  output logic [4:0]             pattern_index,
  output logic [12:0]            pattern_base,
  output logic                   fifo_refill,
  output logic                   mem_clk_en,
  output logic                   pixel_clk_en
);
  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]  index;              // Stored index byte
  logic [7:0]  vertical_coarse_reg;// Vertical bits 10..3
  logic [7:0]  horizontal_coarse_reg;// Pending horizontal coarse
  logic [2:0]  hfine_pend;         // Pending horizontal fine
  logic [7:0]  path_control_reg;   // Data path control
  logic [4:0]  pattern_offset_reg; // Pattern select
  logic [7:0]  scratch_a_reg;      // Firmware scratch
  logic [7:0]  scratch_b_reg;      // Firmware scratch
  logic [7:0]  tuning_reg;         // Performance tuning
  cdx_pkg::cdx_pos_s cur_q;        // Cursor position
  cdx_pkg::cdx_pos_s ico_q;        // Icon position
  logic [7:0]  next_index, next_vc, next_hc, next_pc, next_sa, next_sb, next_tu;
  logic [2:0]  next_hfine;
  logic [4:0]  next_po;
  cdx_pkg::cdx_pos_s next_cur, next_ico;
  logic [4:0]  widx;               // Effective register index
  logic        dwr;                // Effective data write
  logic [7:0]  wbyte;              // Effective data byte
  logic [7:0]  widx8;              // Effective full index
  // ****************************************
  // Register next values
  // ****************************************
  always_comb begin
    next_index = index;
    next_vc    = vertical_coarse_reg;
    next_hc    = horizontal_coarse_reg;
    next_hfine = hfine_pend;
    next_pc    = path_control_reg;
    next_po    = pattern_offset_reg;
    next_sa    = scratch_a_reg;
    next_sb    = scratch_b_reg;
    next_tu    = tuning_reg;
    next_cur   = cur_q;
    next_ico   = ico_q;
    widx8      = index;
    dwr        = host.dat_wr;
    wbyte      = host.wdata;
    if (host_idx16) begin
      widx8 = host_word[7:0];
      wbyte = host_word[15:8];
      dwr   = 1'b1;
    end
    widx = widx8[4:0];
    // Index byte write keeps the fine bits for readback
    if (host.idx_wr) begin
      next_index = host.wdata;
    end else if (host_idx16) begin
      next_index = host_word[7:0];
    end
    if (dwr) begin
      // Only the vertical commit looks at the target bit; no other write is gated
      case (widx)
        `CDX_IDX_VCOARSE: begin
          next_vc = wbyte;
          // Vertical write commits vertical and pending horizontal
          if (!path_control_reg[`CDX_PC_TARGET]) begin
            next_cur.vpos = {wbyte, widx8[7:5]};
            next_cur.hpos = {horizontal_coarse_reg, hfine_pend};
          end else begin
            next_ico.vpos = {wbyte, widx8[7:5]};
            next_ico.hpos = {horizontal_coarse_reg, hfine_pend};
          end
        end
        `CDX_IDX_HCOARSE: begin
          next_hc    = wbyte;
          next_hfine = widx8[7:5];
        end
        `CDX_IDX_PATH:      next_pc = wbyte;
        `CDX_IDX_PATTERN:   next_po = wbyte[4:0];
        `CDX_IDX_SCRATCH_A: next_sa = wbyte;
        `CDX_IDX_SCRATCH_B: next_sb = wbyte;
        `CDX_IDX_TUNING:    next_tu = wbyte;
        default:            next_tu = tuning_reg; // Unmapped: ignored
      endcase
    end
  end
  // Register update, synchronous reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      index                 <= `CDX_RST_ZERO;
      vertical_coarse_reg   <= `CDX_RST_ZERO;
      horizontal_coarse_reg <= `CDX_RST_ZERO;
      hfine_pend            <= 3'h0;
      path_control_reg      <= `CDX_RST_ZERO;
      pattern_offset_reg    <= 5'h00;
      scratch_a_reg         <= `CDX_RST_ZERO;
      scratch_b_reg         <= `CDX_RST_ZERO;
      tuning_reg            <= `CDX_RST_TUNING;
      cur_q                 <= '0;
      ico_q                 <= '0;
    end else begin
      index                 <= next_index;
      vertical_coarse_reg   <= next_vc;
      horizontal_coarse_reg <= next_hc;
      hfine_pend            <= next_hfine;
      path_control_reg      <= next_pc;
      pattern_offset_reg    <= next_po;
      scratch_a_reg         <= next_sa;
      scratch_b_reg         <= next_sb;
      tuning_reg            <= next_tu;
      cur_q                 <= next_cur;
      ico_q                 <= next_ico;
    end
  end
  // ****************************************
  // Read data (registered)
  // ****************************************
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = host_rdata;
    if (host.idx_rd) begin
      next_rdata = index;
    end else if (host.dat_rd) begin
      case (index[4:0])
        `CDX_IDX_VCOARSE:   next_rdata = vertical_coarse_reg;
        `CDX_IDX_HCOARSE:   next_rdata = horizontal_coarse_reg;
        `CDX_IDX_PATH:      next_rdata = path_control_reg;
        `CDX_IDX_PATTERN:   next_rdata = {3'h0, pattern_offset_reg};
        `CDX_IDX_SCRATCH_A: next_rdata = scratch_a_reg;
        `CDX_IDX_SCRATCH_B: next_rdata = scratch_b_reg;
        `CDX_IDX_TUNING:    next_rdata = tuning_reg;
        default:            next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) host_rdata <= 8'h00;
    else          host_rdata <= next_rdata;
  end
  // ****************************************
  // Wait state counter
  // ****************************************
  logic [2:0] wait_cnt, next_wait;
  logic       busy, next_busy;
  logic [2:0] io_waits, mw_waits;
  always_comb begin
    // 00 -> 1, 01/10 -> 2, 11 -> 3
    io_waits = 3'(tuning_reg[7]) + 3'(tuning_reg[6]) + 3'h1;
    // 2..5 plus one with bit 7, max 6
    mw_waits = 3'(tuning_reg[5:4]) + 3'h2 + 3'(tuning_reg[7]);
    next_wait = wait_cnt;
    next_busy = busy;
    if (!busy) begin
      case (cyc_start)
        cdx_pkg::CDX_IO: begin
          next_busy = 1'b1;
          next_wait = io_waits;
        end
        cdx_pkg::CDX_MEMWR: begin
          next_busy = 1'b1;
          next_wait = mw_waits;
        end
        default: next_busy = 1'b0;
      endcase
    end else if (wait_cnt == 3'h0) begin
      next_busy = 1'b0;
    end else begin
      next_wait = wait_cnt - 3'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wait_cnt <= 3'h0;
      busy     <= 1'b0;
    end else begin
      wait_cnt <= next_wait;
      busy     <= next_busy;
    end
  end
  // Ready after the programmed wait states
  assign host_ready = busy && (wait_cnt == 3'h0);
  // ****************************************
  // Clock divide enables
  // ****************************************
  logic [1:0] div_cnt, next_div;
  always_comb next_div = osc_tick ? div_cnt + 2'h1 : div_cnt;
  always_ff @(posedge clock) begin
    if (!reset_n) div_cnt <= 2'h0;
    else          div_cnt <= next_div;
  end
  assign pixel_clk_en = osc_tick && (!pixel_div4 || div_cnt == 2'h3);
  assign mem_clk_en   = osc_tick && (!mem_div2 || div_cnt[0]);
  // ****************************************
  // Decoded controls
  // ****************************************
  assign cursor_pos         = cur_q;
  assign icon_pos           = ico_q;
  assign border_from_hidden = path_control_reg[`CDX_PC_BORDER];
  assign border_color_sel   = border_from_hidden ? {2'h0, `CDX_PAL_BORDER} : attribute_overscan_field;
  assign mem_pins_oe_n      = path_control_reg[`CDX_PC_MEM_TRI];
  assign pixel_div4         = path_control_reg[`CDX_PC_VDIV4];
  assign mem_div2           = path_control_reg[`CDX_PC_MDIV2];
  assign cursor_large       = path_control_reg[`CDX_PC_CSIZE];
  assign palette_ext        = path_control_reg[`CDX_PC_PAL_EXT];
  assign cursor_shown       = path_control_reg[`CDX_PC_CUR_EN];
  // Large cursor ignores the two low pattern bits
  assign pattern_index = cursor_large ? {2'h0, pattern_offset_reg[4:2]} : pattern_offset_reg;
  // Byte offset within the 8K pattern area in the top 32K
  assign pattern_base  = cursor_large ? {pattern_offset_reg[4:2], 10'h000}
                                      : {pattern_offset_reg, 8'h00};
  // Refill at threshold; zero always requests
  assign fifo_refill = (tuning_reg[3:0] == 4'h0) || (fifo_level <= tuning_reg[3:0]);
  // ****************************************
  // Assertions
  // ****************************************
  chk_scratch_reset: assert property (@(posedge clock) !reset_n |=> scratch_a_reg == 8'h00)
    else $error("scratch not cleared");
  chk_tuning_reset: assert property (@(posedge clock) !reset_n |=> tuning_reg == 8'hf0)
    else $error("tuning reset wrong");
  chk_vert_commit: assert property (@(posedge clock) disable iff (!reset_n)
    host.dat_wr && !host_idx16 && index[4:0] == 5'h11 && !path_control_reg[3]
    |=> cur_q.vpos == {$past(host.wdata), $past(index[7:5])})
    else $error("cursor vertical not committed");
  chk_horiz_pending: assert property (@(posedge clock) disable iff (!reset_n)
    host.dat_wr && !host_idx16 && index[4:0] == 5'h10 |=> $stable(cur_q.hpos) && $stable(ico_q.hpos))
    else $error("horizontal applied early");
  // Index byte write, a quiet cycle, then an index port read
  chk_idx_readback: assert property (@(posedge clock) disable iff (!reset_n)
    host.idx_wr ##1 !host.idx_wr && !host_idx16 ##1 host.idx_rd && !host.idx_wr && !host_idx16
    |=> host_rdata == $past(host.wdata, 3))
    else $error("index readback wrong");
  chk_io_ready: assert property (@(posedge clock) disable iff (!reset_n)
    !busy && cyc_start == cdx_pkg::CDX_IO && tuning_reg[7:6] == 2'h0 |=> !host_ready ##1 host_ready)
    else $error("io wait count wrong");
  chk_pattern_large: assert property (@(posedge clock) disable iff (!reset_n)
    cursor_large |-> pattern_index[4:3] == 2'h0)
    else $error("large pattern index wide");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
    host.dat_rd && !host.idx_rd && index[4:0] == 5'h13 |=> host_rdata[7:5] == 3'h0)
    else $error("reserved bits nonzero");
  cov_vert16: cover property (@(posedge clock) host_idx16 && host_word[4:0] == 5'h11);
  cov_memwr: cover property (@(posedge clock) host_ready && $past(cyc_start) == cdx_pkg::CDX_MEMWR);
  cov_icon: cover property (@(posedge clock) ico_q.vpos != 11'h000);
  cov_large_pattern: cover property (@(posedge clock) cursor_large && pattern_offset_reg[4:2] == 3'h7);
  cov_refill_zero: cover property (@(posedge clock) fifo_refill && tuning_reg[3:0] == 4'h0);
endmodule : cdx_regs
